// ---- hw/pdcr_cfg.svh ----
`ifndef PDCR_CFG_SVH
`define PDCR_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PDCR_ADDR_W 12
`define PDCR_CAP_OFF 12'h0E4
`define PDCR_LAT_OFF 12'h0F0
`define PDCR_STAT_OFF 12'h0F4

// ****************************************
// Capability word field positions
// ****************************************
`define PDCR_MPS_LSB 0
`define PDCR_MPS_MSB 2
`define PDCR_PHF_LSB 3
`define PDCR_PHF_MSB 4
`define PDCR_ETAG_BIT 5
`define PDCR_L0S_LSB 6
`define PDCR_L0S_MSB 8
`define PDCR_L1_LSB 9
`define PDCR_L1_MSB 11
`define PDCR_ABP_BIT 12
`define PDCR_AIP_BIT 13
`define PDCR_PIP_BIT 14
`define PDCR_RBER_BIT 15
`define PDCR_RSV0_LSB 16
`define PDCR_RSV0_MSB 17
`define PDCR_SPLV_LSB 18
`define PDCR_SPLV_MSB 25
`define PDCR_SPLS_LSB 26
`define PDCR_SPLS_MSB 27
`define PDCR_RSV1_LSB 28
`define PDCR_RSV1_MSB 31

// ****************************************
// Latency config register layout
// ****************************************
`define PDCR_CFG_L0S_LSB 0
`define PDCR_CFG_L0S_MSB 2
`define PDCR_CFG_L1_LSB 3
`define PDCR_CFG_L1_MSB 5

// ****************************************
// Status register layout
// ****************************************
`define PDCR_STAT_CNT_LSB 0
`define PDCR_STAT_CNT_MSB 7
`define PDCR_STAT_EE_BIT 8

// ****************************************
// Reset and hardwired values
// ****************************************
`define PDCR_MPS_VAL 3'h0
`define PDCR_PHF_VAL 2'h0
`define PDCR_BIT0_VAL 1'h0
`define PDCR_LAT_RST 3'h0
`define PDCR_RBER_RST 1'h1
`define PDCR_SPLV_RST 8'h00
`define PDCR_SPLS_RST 2'h0
`define PDCR_CAP_RST 32'h0000_8000
`define PDCR_CNT_RST 8'h00

`endif

// ---- hw/pdcr_pkg.sv ----
package pdcr_pkg;
    typedef logic [31:0] pdcr_word_t;
    typedef logic [11:0] pdcr_addr_t;
    typedef enum logic [1:0] {
        PDCR_IDLE = 2'b00,
        PDCR_RESP = 2'b01
    } pdcr_state_t;
endpackage

// ---- hw/pdcr_capture.sv ----
`timescale 1ns/100ps
`include "pdcr_cfg.svh"

module pdcr_capture (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic spl_msg_valid_i,
    input wire logic [7:0] spl_msg_value_i,
    input wire logic [1:0] spl_msg_scale_i,
    input wire logic ee_load_valid_i,
    input wire logic ee_rber_i,
    output logic [7:0] spl_value_o,
    output logic [1:0] spl_scale_o,
    output logic rber_o,
    output logic [7:0] msg_count_o,
    output logic ee_loaded_o
);
    import pdcr_pkg::*;

    // ****************************************
    // Slot power limit capture
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            spl_value_o <= `PDCR_SPLV_RST;
            spl_scale_o <= `PDCR_SPLS_RST;
        end else if (spl_msg_valid_i) begin
            spl_value_o <= spl_msg_value_i;
            spl_scale_o <= spl_msg_scale_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            msg_count_o <= `PDCR_CNT_RST;
        end else if (spl_msg_valid_i) begin
            msg_count_o <= msg_count_o + 8'h01;
        end
    end

    // ****************************************
    // EEPROM override of error reporting bit
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rber_o <= `PDCR_RBER_RST;
            ee_loaded_o <= 1'b0;
        end else if (ee_load_valid_i) begin
            rber_o <= ee_rber_i;
            ee_loaded_o <= 1'b1;
        end
    end
endmodule // pdcr_capture

// ---- hw/pdcr_top.sv ----
// Function
// - Phantom function field, bits 4:3, always reads zero.
// - Extended tag bit 5 and indicator bits 12 to 14 read zero.
// - L0s latency bits 8:6 and L1 latency bits 11:9 reset to zero.
// - Error reporting bit 15 resets to one; EEPROM load may replace it.
// - Slot power value, bits 25:18, latched from each limit message.
// - Slot power scale, bits 27:26, latched from the same message.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "pdcr_cfg.svh"

module pdcr_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pdcr_pkg::pdcr_addr_t paddr,
    input wire pdcr_pkg::pdcr_word_t pwdata,
    output pdcr_pkg::pdcr_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spl_msg_valid_i,
    input wire logic [7:0] spl_msg_value_i,
    input wire logic [1:0] spl_msg_scale_i,
    input wire logic ee_load_valid_i,
    input wire logic ee_rber_i,
    output pdcr_pkg::pdcr_word_t cap_word_o,
    output logic [7:0] spl_value_o,
    output logic [1:0] spl_scale_o
);
    import pdcr_pkg::*;

    pdcr_state_t st_r;
    logic [2:0] l0s_lat_r;
    logic [2:0] l1_lat_r;
    logic [7:0] cap_value;
    logic [1:0] cap_scale;
    logic cap_rber;
    logic [7:0] msg_count;
    logic ee_loaded;
    pdcr_word_t cap_nxt;
    pdcr_word_t rd_nxt;
    logic access;
    logic commit;

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic pdcr_word_t build_cap(
        input logic [2:0] l0s,
        input logic [2:0] l1,
        input logic rber,
        input logic [7:0] splv,
        input logic [1:0] spls
    );
        pdcr_word_t w;
        w = 32'h0000_0000;
        w[`PDCR_MPS_MSB:`PDCR_MPS_LSB] = `PDCR_MPS_VAL;
        w[`PDCR_PHF_MSB:`PDCR_PHF_LSB] = `PDCR_PHF_VAL;
        w[`PDCR_ETAG_BIT] = `PDCR_BIT0_VAL;
        w[`PDCR_L0S_MSB:`PDCR_L0S_LSB] = l0s;
        w[`PDCR_L1_MSB:`PDCR_L1_LSB] = l1;
        w[`PDCR_ABP_BIT] = `PDCR_BIT0_VAL;
        w[`PDCR_AIP_BIT] = `PDCR_BIT0_VAL;
        w[`PDCR_PIP_BIT] = `PDCR_BIT0_VAL;
        w[`PDCR_RBER_BIT] = rber;
        w[`PDCR_SPLV_MSB:`PDCR_SPLV_LSB] = splv;
        w[`PDCR_SPLS_MSB:`PDCR_SPLS_LSB] = spls;
        return w;
    endfunction

    function automatic logic is_mapped(input pdcr_addr_t a);
        logic hit;
        hit = 1'b0;
        if (a == `PDCR_CAP_OFF) begin
            hit = 1'b1;
        end else if (a == `PDCR_LAT_OFF) begin
            hit = 1'b1;
        end else if (a == `PDCR_STAT_OFF) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ****************************************
    // Captured and loaded fields
    // ****************************************
    pdcr_capture u_capture (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .spl_msg_valid_i(spl_msg_valid_i),
        .spl_msg_value_i(spl_msg_value_i),
        .spl_msg_scale_i(spl_msg_scale_i),
        .ee_load_valid_i(ee_load_valid_i),
        .ee_rber_i(ee_rber_i),
        .spl_value_o(cap_value),
        .spl_scale_o(cap_scale),
        .rber_o(cap_rber),
        .msg_count_o(msg_count),
        .ee_loaded_o(ee_loaded)
    );

    assign cap_nxt = build_cap(l0s_lat_r, l1_lat_r, cap_rber,
                               cap_value, cap_scale);

    // ****************************************
    // Capability word outputs
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_word_o <= `PDCR_CAP_RST;
            spl_value_o <= `PDCR_SPLV_RST;
            spl_scale_o <= `PDCR_SPLS_RST;
        end else begin
            cap_word_o <= cap_nxt;
            spl_value_o <= cap_value;
            spl_scale_o <= cap_scale;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign access = psel & penable;
    assign commit = access & (st_r == PDCR_RESP);

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (paddr == `PDCR_CAP_OFF) begin
            rd_nxt = cap_nxt;
        end else if (paddr == `PDCR_LAT_OFF) begin
            rd_nxt[`PDCR_CFG_L0S_MSB:`PDCR_CFG_L0S_LSB] = l0s_lat_r;
            rd_nxt[`PDCR_CFG_L1_MSB:`PDCR_CFG_L1_LSB] = l1_lat_r;
        end else if (paddr == `PDCR_STAT_OFF) begin
            rd_nxt[`PDCR_STAT_CNT_MSB:`PDCR_STAT_CNT_LSB] = msg_count;
            rd_nxt[`PDCR_STAT_EE_BIT] = ee_loaded;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= PDCR_IDLE;
        end else begin
            case (st_r)
                PDCR_IDLE: begin
                    if (access) begin
                        st_r <= PDCR_RESP;
                    end
                end
                PDCR_RESP: begin
                    st_r <= PDCR_IDLE;
                end
                default: begin
                    st_r <= PDCR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (st_r == PDCR_IDLE && access) begin
            pready <= 1'b1;
            pslverr <= ~is_mapped(paddr);
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Latency config register
    // ****************************************
    // Capability word offset has no write path at all
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l0s_lat_r <= `PDCR_LAT_RST;
            l1_lat_r <= `PDCR_LAT_RST;
        end else if (commit && pwrite && paddr == `PDCR_LAT_OFF) begin
            l0s_lat_r <= pwdata[`PDCR_CFG_L0S_MSB:`PDCR_CFG_L0S_LSB];
            l1_lat_r <= pwdata[`PDCR_CFG_L1_MSB:`PDCR_CFG_L1_LSB];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_phantom_zero;
        cap_word_o[`PDCR_PHF_MSB:`PDCR_PHF_LSB] == 2'h0;
    endproperty
    a_phantom_zero: assert property (p_phantom_zero)
        else $error("phantom function field not zero");

    property p_fixed_zero;
        !cap_word_o[`PDCR_ETAG_BIT] && !cap_word_o[`PDCR_ABP_BIT] &&
        !cap_word_o[`PDCR_AIP_BIT] && !cap_word_o[`PDCR_PIP_BIT];
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("hardwired zero bit is set");

    property p_lat_follow;
        cap_word_o[`PDCR_L1_MSB:`PDCR_L0S_LSB] ==
            {$past(l1_lat_r), $past(l0s_lat_r)};
    endproperty
    a_lat_follow: assert property (p_lat_follow)
        else $error("latency fields do not follow config");

    property p_lat_write;
        commit && pwrite && paddr == `PDCR_LAT_OFF |=>
            l0s_lat_r == $past(pwdata[`PDCR_CFG_L0S_MSB:`PDCR_CFG_L0S_LSB])
            ##1 cap_word_o[`PDCR_L0S_MSB:`PDCR_L0S_LSB] == $past(l0s_lat_r);
    endproperty
    a_lat_write: assert property (p_lat_write)
        else $error("latency write not reflected");

    property p_rber_load;
        ee_load_valid_i |-> ##2 cap_word_o[`PDCR_RBER_BIT] == $past(ee_rber_i, 2);
    endproperty
    a_rber_load: assert property (p_rber_load)
        else $error("eeprom error reporting value lost");

    property p_rber_hold;
        !ee_load_valid_i ##1 !ee_load_valid_i |=>
            $stable(cap_word_o[`PDCR_RBER_BIT]);
    endproperty
    a_rber_hold: assert property (p_rber_hold)
        else $error("error reporting bit changed without load");

    property p_value_capture;
        spl_msg_valid_i |-> ##2
            cap_word_o[`PDCR_SPLV_MSB:`PDCR_SPLV_LSB] ==
            $past(spl_msg_value_i, 2) && spl_value_o == $past(spl_msg_value_i, 2);
    endproperty
    a_value_capture: assert property (p_value_capture)
        else $error("slot power value not captured");

    property p_scale_capture;
        spl_msg_valid_i |-> ##2
            cap_word_o[`PDCR_SPLS_MSB:`PDCR_SPLS_LSB] ==
            $past(spl_msg_scale_i, 2) && spl_scale_o == $past(spl_msg_scale_i, 2);
    endproperty
    a_scale_capture: assert property (p_scale_capture)
        else $error("slot power scale not captured");

    property p_power_hold;
        !spl_msg_valid_i ##1 !spl_msg_valid_i |=>
            $stable(cap_word_o[`PDCR_SPLS_MSB:`PDCR_SPLV_LSB]);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("slot power fields changed without message");

    property p_reserved_zero;
        cap_word_o[`PDCR_RSV0_MSB:`PDCR_RSV0_LSB] == 2'h0 &&
        cap_word_o[`PDCR_RSV1_MSB:`PDCR_RSV1_LSB] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_cap_write_ignored;
        commit && pwrite && paddr == `PDCR_CAP_OFF && !spl_msg_valid_i &&
        !ee_load_valid_i && $past(!spl_msg_valid_i && !ee_load_valid_i) |->
            !pslverr ##1 $stable(cap_word_o);
    endproperty
    a_cap_write_ignored: assert property (p_cap_write_ignored)
        else $error("write to capability word had effect");

    property p_ready_one_wait;
        access && st_r == PDCR_IDLE |=> pready ##1 !pready;
    endproperty
    a_ready_one_wait: assert property (p_ready_one_wait)
        else $error("apb ready timing wrong");

    property p_err_unmapped;
        pready && pslverr |-> !is_mapped(paddr);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error answer on mapped address");

    property p_prdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_prdata_idle: assert property (p_prdata_idle)
        else $error("read data not cleared outside answer");

    property p_err_data_zero;
        pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_err_data_zero: assert property (p_err_data_zero)
        else $error("error answer carries data");

    property p_count_step;
        spl_msg_valid_i |=> msg_count == $past(msg_count) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("message counter did not advance");

    property p_ee_seen;
        ee_load_valid_i |=> ee_loaded && cap_rber == $past(ee_rber_i);
    endproperty
    a_ee_seen: assert property (p_ee_seen)
        else $error("eeprom load not recorded");
endmodule // pdcr_top

// ---- dv/pdcr_up_port.sv ----
`timescale 1ns/100ps

// ****************************************
// Upstream port: limit messages and EEPROM load
// ****************************************
module pdcr_up_port (
    input wire logic sys_clk_i,
    output logic msg_valid_o,
    output logic [7:0] msg_value_o,
    output logic [1:0] msg_scale_o,
    output logic ee_valid_o,
    output logic ee_rber_o
);
    initial begin
        msg_valid_o = 1'h0;
        msg_value_o = 8'h5A;
        msg_scale_o = 2'h1;
        ee_valid_o = 1'h0;
        ee_rber_o = 1'h0;
    end

    // One payload per cycle, back to back allowed
    task send(input logic [7:0] v, input logic [1:0] s);
        @(posedge sys_clk_i);
        msg_valid_o <= 1'h1;
        msg_value_o <= v;
        msg_scale_o <= s;
    endtask

    // Payload lines stop holding once the message ends
    task idle();
        @(posedge sys_clk_i);
        msg_valid_o <= 1'h0;
        msg_value_o <= ~msg_value_o;
        msg_scale_o <= ~msg_scale_o;
    endtask

    task ee_load(input logic b);
        @(posedge sys_clk_i);
        ee_valid_o <= 1'h1;
        ee_rber_o <= b;
        @(posedge sys_clk_i);
        ee_valid_o <= 1'h0;
        ee_rber_o <= ~b;
    endtask
endmodule // pdcr_up_port

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`include "pdcr_cfg.svh"

module tb_top;
    import pdcr_pkg::*;
    logic sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
    pdcr_addr_t paddr;
    pdcr_word_t pwdata, prdata, cap_word_o, rd;
    logic m_v, e_v, e_b, er, x_rb, x_ee;
    logic [7:0] m_val, spl_value_o, x_v, x_cnt;
    logic [1:0] m_sc, spl_scale_o, x_s;
    logic [2:0] x_l0s, x_l1;
    int failures, checks_done;

    pdcr_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spl_msg_valid_i(m_v), .spl_msg_value_i(m_val),
        .spl_msg_scale_i(m_sc), .ee_load_valid_i(e_v), .ee_rber_i(e_b),
        .cap_word_o(cap_word_o), .spl_value_o(spl_value_o),
        .spl_scale_o(spl_scale_o));
    pdcr_up_port up_u (.sys_clk_i(sys_clk_i), .msg_valid_o(m_v),
        .msg_value_o(m_val), .msg_scale_o(m_sc), .ee_valid_o(e_v),
        .ee_rber_o(e_b));

    initial begin
        sys_clk_i = 1'h0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic pdcr_word_t exp_cap();
        return {4'h0, x_s, x_v, 2'h0, x_rb, 3'h0, x_l1, x_l0s, 6'h00};
    endfunction

    task chk(input pdcr_word_t got, input pdcr_word_t exp, input string w);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: %s got %h exp %h", $time, w, got, exp);
        end
    endtask

    task close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task apb(input logic wr, input pdcr_addr_t a, input pdcr_word_t wd);
        int n;
        @(posedge sys_clk_i);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            failures++;
            $display("Error %0t: no ready", $time);
            close_out();
        end
    endtask

    task rd_cap(input string w);
        apb(1'h0, `PDCR_CAP_OFF, 32'h0);
        chk(rd, exp_cap(), w);
        chk(32'(er), 32'h0, w);
    endtask

    task rd_stat();
        apb(1'h0, `PDCR_STAT_OFF, 32'h0);
        chk(rd, {23'h0, x_ee, x_cnt}, "status");
    endtask

    task reset_dut();
        rst_i <= 1'h1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        {x_l0s, x_l1, x_v, x_s, x_cnt, x_ee} = '0;
        x_rb = 1'h1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        reset_dut();
        @(posedge sys_clk_i);
        #1;
        chk(cap_word_o, 32'h00008000, "cap out");
        chk(32'(spl_value_o), 32'h0, "value");
        chk(32'(spl_scale_o), 32'h0, "scale");
        rd_cap("cap reset");
        $display("test reset done");
    endtask

    task t_lat();
        for (int i = 0; i < 8; i++) begin
            x_l0s = 3'(i);
            x_l1 = 3'(7 - i);
            apb(1'h1, `PDCR_LAT_OFF, {26'h0, x_l1, x_l0s});
            rd_cap("latency");
        end
        $display("test latency done");
    endtask

    task t_msg();
        for (int s = 0; s < 4; s++) begin
            up_u.send(8'hFF, 2'(s ^ 3));
            up_u.send(8'(8'h81 + s), 2'(s));
            up_u.idle();
            x_cnt += 8'h02;
            x_v = 8'(8'h81 + s);
            x_s = 2'(s);
            repeat (2) @(posedge sys_clk_i);
            #1;
            chk(cap_word_o, exp_cap(), "cap msg");
            chk(32'(spl_value_o), 32'(x_v), "value");
            chk(32'(spl_scale_o), 32'(x_s), "scale");
            rd_cap("cap msg read");
        end
        rd_stat();
        $display("test message done");
    endtask

    task t_ee();
        for (int b = 0; b < 2; b++) begin
            up_u.ee_load(1'(b));
            x_rb = 1'(b);
            x_ee = 1'h1;
            repeat (2) @(posedge sys_clk_i);
            #1;
            chk(cap_word_o, exp_cap(), "cap ee");
            rd_cap("cap ee read");
            rd_stat();
        end
        reset_dut();
        rd_cap("cap rerun");
        $display("test eeprom done");
    endtask

    task t_ro();
        x_l0s = 3'h7;
        apb(1'h1, `PDCR_LAT_OFF, 32'h00000007);
        apb(1'h1, `PDCR_CAP_OFF, 32'hFFFFFFFF);
        chk(32'(er), 32'h0, "cap write err");
        rd_cap("cap after write");
        apb(1'h1, `PDCR_STAT_OFF, 32'hFFFFFFFF);
        rd_stat();
        apb(1'h1, 12'h100, 32'hFFFFFFFF);
        chk(32'(er), 32'h1, "unmapped write");
        apb(1'h0, 12'h100, 32'h0);
        chk(32'(er), 32'h1, "unmapped read");
        chk(rd, 32'h0, "unmapped data");
        rd_cap("cap after unmapped");
        $display("test read only done");
    endtask

    initial begin
        failures = 0;
        checks_done = 0;
        rst_i = 1'h1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        t_reset();
        t_lat();
        t_msg();
        t_ee();
        t_ro();
        close_out();
    end
endmodule // tb_top
